// ==== hdl/lbd_divider.sv ====
`timescale 1ns/1ns
module lbd_divider
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [7:0] divisor,
  output logic            sw_clk
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       clk_q;
  logic       clk_d;
  logic       wrap;
  logic [7:0] half;

  // Half period toggling gives a 50% duty clock for the even divisors.
  assign half  = divisor >> 1;
  assign wrap  = (cnt_q >= half - 8'h01);
  assign cnt_d = (!run || wrap) ? 8'h00 : cnt_q + 8'h01;
  assign clk_d = !run ? 1'b0 : (wrap ? ~clk_q : clk_q);

  // Counter and output flop; a stopped stage holds the clock low.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q <= 8'h00;
      clk_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign sw_clk = clk_q;

endmodule

// ==== hdl/lbd_pkg.sv ====
package lbd_pkg;

  // Register addresses in the device map.
  localparam logic [7:0] CTRL_ADDR     = 8'h04;
  localparam logic [7:0] FREQ_ADDR     = 8'h10;
  localparam logic [7:0] SETPOINT_ADDR = 8'h11;
  localparam logic [7:0] SLOPE_ADDR    = 8'h12;

  // Field positions.
  localparam int LED_EN_BIT     = 1;
  localparam int INT_SEL_BIT    = 7;
  localparam int LOW_SLOPE_LSB  = 0;
  localparam int HIGH_SLOPE_LSB = 2;

  // Values after reset.
  localparam logic [5:0] FREQ_CODE_RESET = 6'h04;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] SETPOINT_RESET  = 8'h00;
  localparam logic [7:0] SLOPE_RESET     = 8'h00;
  localparam logic [7:0] DIVISOR_RESET   = 8'h10;

  // Highest legal frequency code; codes above it keep the reset divisor.
  localparam logic [5:0] FREQ_CODE_MAX = 6'h1a;

  // Set-point source selection.
  typedef enum logic [1:0]
  {
    SRC_ZERO     = 2'b00,
    SRC_ANALOG   = 2'b01,
    SRC_INTERNAL = 2'b10
  } lbd_src_type;

  // Register read or write request.
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lbd_req_type;

endpackage

// ==== hdl/lbd_top.sv ====
`timescale 1ns/1ns
// Contract
// RL1 - Stage switches only while enable bit set.
// RL2 - External PWM low selects zero-current level.
// RL3 - External PWM high selects analog set-point pin.
// RL4 - Internal select bit routes DAC to node.
// RL5 - DAC output is reference times code+1 over 128.
// RL6 - Switching clock is main clock over divisor.
// RL7 - Frequency code maps to the divisor table.
// RL8 - Reset frequency code is 4, divisor 16.
// RL9 - Low-duty slope codes give 0.1 to 0.4.
// RL10 - High-duty slope codes give 0.3 to 0.9.
// RL11 - Both slope codes reset to zero.
// RL12 - Host zeroes slopes when phase margin low.
// RL13 - External PWM kept below about 2 kHz.
// RL14 - Control register sits at address 0x04.
// RL15 - PWM input synchronised before driving the selector.
module lbd_top
(
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       CE,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  output logic            REG_ACK,
  input  wire logic       PWM_IN,
  output logic            LED_DRIVE_ENABLE,
  output logic            SWITCHING_CLOCK,
  output logic      [1:0] SETPOINT_SOURCE,
  output logic      [6:0] DAC_CODE,
  output logic      [7:0] DAC_STEPS,
  output logic      [1:0] LOW_DUTY_SLOPE,
  output logic      [1:0] HIGH_DUTY_SLOPE,
  output logic      [7:0] SWITCH_DIVISOR
);

  // Map a frequency code to its divisor; illegal codes fall back to the reset value.
  function automatic logic [7:0] freq_divisor(input logic [5:0] code);
    logic [7:0] d;
    d = lbd_pkg::DIVISOR_RESET;
    if (code <= 6'h0a)
    begin
      d = 8'h08 + {1'b0, code, 1'b0};
    end
    else
    begin
      // Above code ten the steps are irregular, so they are listed one by one.
      unique case (code)
        6'h0b:   d = 8'h20;
        6'h0c:   d = 8'h22;
        6'h0d:   d = 8'h26;
        6'h0e:   d = 8'h2a;
        6'h0f:   d = 8'h2e;
        6'h10:   d = 8'h34;
        6'h11:   d = 8'h38;
        6'h12:   d = 8'h40;
        6'h13:   d = 8'h46;
        6'h14:   d = 8'h4c;
        6'h15:   d = 8'h54;
        6'h16:   d = 8'h66;
        6'h17:   d = 8'h70;
        6'h18:   d = 8'h7c;
        6'h19:   d = 8'h96;
        6'h1a:   d = 8'hb4;
        default: d = lbd_pkg::DIVISOR_RESET;
      endcase
    end
    return d;
  endfunction

  // Converter numerator: code plus one, so code zero still yields one step of the reference.
  function automatic logic [7:0] dac_steps(input logic [6:0] code);
    return {1'b0, code} + 8'h01;
  endfunction

  // Bus request and stored register fields.
  lbd_pkg::lbd_req_type req;
  logic [7:0]           ctrl_q;
  logic [5:0]           freq_q;
  logic [7:0]           setpoint_q;
  logic [3:0]           slope_q;
  logic [7:0]           steps_q;

  // Bus answer, divisor and dimming-pin synchroniser.
  logic [7:0]           rdata_q;
  logic                 ack_q;
  logic [7:0]           div_q;
  logic [2:0]           pwm_sync_q;
  logic                 pwm_level_q;

  // Decode and selection wires.
  logic                 wr_ctrl;
  logic                 wr_freq;
  logic                 wr_setpoint;
  logic                 wr_slope;
  logic [7:0]           rd_mux;
  logic                 led_en;
  logic                 int_sel;
  lbd_pkg::lbd_src_type src;

  // The bus pins travel together as one request word.
  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // Address decode for writes.
  assign wr_ctrl     = req.wr && (req.addr == lbd_pkg::CTRL_ADDR); // RL14
  assign wr_freq     = req.wr && (req.addr == lbd_pkg::FREQ_ADDR);
  assign wr_setpoint = req.wr && (req.addr == lbd_pkg::SETPOINT_ADDR);
  assign wr_slope    = req.wr && (req.addr == lbd_pkg::SLOPE_ADDR);

  // Read selection; unmapped addresses read zero.
  assign rd_mux = (req.addr == lbd_pkg::CTRL_ADDR)     ? ctrl_q :
                  (req.addr == lbd_pkg::FREQ_ADDR)     ? {2'b00, freq_q} :
                  (req.addr == lbd_pkg::SETPOINT_ADDR) ? setpoint_q :
                  (req.addr == lbd_pkg::SLOPE_ADDR)    ? {4'h0, slope_q} : 8'h00;

  // Register storage.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ctrl_q     <= lbd_pkg::CTRL_RESET;
      freq_q     <= lbd_pkg::FREQ_CODE_RESET; // RL8
      setpoint_q <= lbd_pkg::SETPOINT_RESET;
      slope_q    <= lbd_pkg::SLOPE_RESET[3:0]; // RL11
    end
    else if (CE)
    begin
      if (wr_ctrl)
        ctrl_q <= req.wdata;
      if (wr_freq)
        freq_q <= req.wdata[5:0];
      if (wr_setpoint)
        setpoint_q <= req.wdata;
      if (wr_slope)
        slope_q <= req.wdata[3:0];
    end
  end

  // The numerator is stored beside the code, so the converter output comes straight from a flop.
  // It updates on the same edge as the code, which keeps the two consistent at every sample.
  always_ff @(posedge CLK)
  begin
    if (RESET)
      steps_q <= dac_steps(lbd_pkg::SETPOINT_RESET[6:0]); // RL5
    else if (CE && wr_setpoint)
      steps_q <= dac_steps(req.wdata[6:0]); // RL5
  end

  // Read data and acknowledge, one cycle after the strobe.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      rdata_q <= 8'h00;
      ack_q   <= 1'b0;
    end
    else if (CE)
    begin
      rdata_q <= req.rd ? rd_mux : rdata_q;
      ack_q   <= req.rd || req.wr;
    end
  end

  // Divisor is registered so the table lookup stays off the divider path.
  always_ff @(posedge CLK)
  begin
    if (RESET)
      div_q <= lbd_pkg::DIVISOR_RESET;
    else if (CE)
      div_q <= freq_divisor(freq_q); // RL7
  end

  // Three stages; only the second and third are compared, so a metastable first stage never reaches logic.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pwm_sync_q  <= 3'b000;
      pwm_level_q <= 1'b0;
    end
    else if (CE)
    begin
      pwm_sync_q <= {pwm_sync_q[1:0], PWM_IN}; // RL15
      if (pwm_sync_q[1] == pwm_sync_q[2])
        pwm_level_q <= pwm_sync_q[2]; // RL15
    end
  end

  // Control fields taken from the stored registers.
  assign led_en  = ctrl_q[lbd_pkg::LED_EN_BIT];
  assign int_sel = setpoint_q[lbd_pkg::INT_SEL_BIT];

  // Source selection: the internal DAC overrides the PWM pin entirely.
  assign src = int_sel     ? lbd_pkg::SRC_INTERNAL : // RL4
               pwm_level_q ? lbd_pkg::SRC_ANALOG :   // RL3
                             lbd_pkg::SRC_ZERO;      // RL2

  // Switching clock generator; idle and low while the stage is disabled.
  lbd_divider u_div
  (
    .clk     (CLK),
    .reset   (RESET),
    .ce      (CE),
    .run     (led_en), // RL1
    .divisor (div_q),
    .sw_clk  (SWITCHING_CLOCK) // RL6
  );

  // Analog-facing and bus outputs; DAC_STEPS is the stored numerator over 128.
  assign LED_DRIVE_ENABLE = led_en; // RL1
  assign SETPOINT_SOURCE  = src;
  assign DAC_CODE         = setpoint_q[6:0];
  assign DAC_STEPS        = steps_q; // RL5
  assign LOW_DUTY_SLOPE   = slope_q[lbd_pkg::LOW_SLOPE_LSB +: 2];  // RL9
  assign HIGH_DUTY_SLOPE  = slope_q[lbd_pkg::HIGH_SLOPE_LSB +: 2]; // RL10
  assign SWITCH_DIVISOR   = div_q;
  assign REG_RDATA        = rdata_q;
  assign REG_ACK          = ack_q;

endmodule

// ==== tb/lbd_props.sv ====
`timescale 1ns/1ns
module lbd_props
(
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       CE,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       PWM_IN,
  input wire logic       LED_DRIVE_ENABLE,
  input wire logic       SWITCHING_CLOCK,
  input wire logic [1:0] SETPOINT_SOURCE,
  input wire logic [6:0] DAC_CODE,
  input wire logic [7:0] DAC_STEPS,
  input wire logic [1:0] LOW_DUTY_SLOPE,
  input wire logic [1:0] HIGH_DUTY_SLOPE,
  input wire logic [7:0] SWITCH_DIVISOR
);
  logic       sw_q;
  logic [7:0] cnt_q;
  logic [7:0] div_q;
  logic       arm_q;
  wire        toggle = sw_q != SWITCHING_CLOCK;
  wire        wr_en  = CE && REG_WR;

  default clocking @(posedge CLK);
  endclocking
  default disable iff (RESET);

  // A half period is only judged when it began at a toggle and the divisor held steady, since a change upsets the count.
  always_ff @(posedge CLK)
  begin
    sw_q  <= SWITCHING_CLOCK;
    div_q <= SWITCH_DIVISOR;
    cnt_q <= toggle ? 8'h01 : cnt_q + 8'h01;
    arm_q <= LED_DRIVE_ENABLE && CE && !RESET && div_q == SWITCH_DIVISOR && (toggle || arm_q);
  end

  // Each property ties an output to the input or output that causes it.
  a_enable_write: assert property (wr_en && REG_ADDR == 8'h04 |=> LED_DRIVE_ENABLE == $past(REG_WDATA[1]))
    else $error("Enable bit does not follow the control write.");
  a_idle_stage: assert property (!LED_DRIVE_ENABLE ##1 !LED_DRIVE_ENABLE |-> !SWITCHING_CLOCK)
    else $error("Switching clock runs while disabled.");
  a_zero_route: assert property ((!PWM_IN) [*5] ##0 SETPOINT_SOURCE != 2'b10 |-> SETPOINT_SOURCE == 2'b00)
    else $error("Low PWM does not select the zero level.");
  a_analog_route: assert property (PWM_IN [*5] ##0 SETPOINT_SOURCE != 2'b10 |-> SETPOINT_SOURCE == 2'b01)
    else $error("High PWM does not select the analog pin.");
  a_internal_route: assert property (wr_en && REG_ADDR == 8'h11 && REG_WDATA[7]
    |=> SETPOINT_SOURCE == 2'b10 && DAC_CODE == $past(REG_WDATA[6:0]))
    else $error("Internal select does not route the converter code.");
  a_dac_steps: assert property (DAC_STEPS == {1'b0, DAC_CODE} + 8'h01)
    else $error("Converter steps differ from code plus one.");
  a_reset_defaults: assert property ($fell(RESET) |-> SWITCH_DIVISOR == 8'h10
    && LOW_DUTY_SLOPE == 2'b00 && HIGH_DUTY_SLOPE == 2'b00)
    else $error("Wrong divisor or slope after reset.");
  a_code_zero: assert property (wr_en && REG_ADDR == 8'h10 && REG_WDATA[5:0] == 6'h00
    |-> ##3 SWITCH_DIVISOR == 8'h08)
    else $error("Code zero does not give divisor eight.");
  a_sync_hold: assert property ($changed(PWM_IN) |=> $stable(SETPOINT_SOURCE))
    else $error("Selector reacts to PWM without synchronising.");
  a_switch_period: assert property (toggle && arm_q |-> cnt_q == SWITCH_DIVISOR >> 1)
    else $error("Switching half period differs from half the divisor.");

  c_period: cover property (toggle && arm_q);
  c_analog: cover property (SETPOINT_SOURCE == 2'b01);
  c_internal: cover property (SETPOINT_SOURCE == 2'b10);
endmodule

bind lbd_top lbd_props u_props (.*);

// ==== tb/lbd_pwm_src.sv ====
`timescale 1ns/1ns
// Dimming source; its edges land 37 ns after the clock, as an unrelated pin would.
module lbd_pwm_src
(
  input wire logic        clk,
  input wire logic [13:0] duty,
  output logic            pwm
);
  logic [12:0] cnt_q = 13'h0000;

  // A 13-bit period at 10 MHz keeps the rate near 1.2 kHz.
  always @(posedge clk)
  begin
    cnt_q <= cnt_q + 13'h0001;
    pwm   <= #37 ({1'b0, cnt_q} < duty);
  end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  localparam logic [7:0] DIV_TBL [16] = '{8'h20, 8'h22, 8'h26, 8'h2a, 8'h2e, 8'h34, 8'h38, 8'h40,
                                         8'h46, 8'h4c, 8'h54, 8'h66, 8'h70, 8'h7c, 8'h96, 8'hb4};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [13:0] duty = 14'h0000;
  logic [7:0]  rdata, steps, divisor;
  logic [6:0]  code;
  logic [1:0]  src, low, high;
  logic        ack, pwm, en, sw;
  int          errors = 0;
  int          check_count = 0;
  time         t0;

  lbd_top DUT (.CLK(clk), .RESET(rst), .CE(ce), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_ACK(ack), .PWM_IN(pwm), .LED_DRIVE_ENABLE(en), .SWITCHING_CLOCK(sw),
    .SETPOINT_SOURCE(src), .DAC_CODE(code), .DAC_STEPS(steps), .LOW_DUTY_SLOPE(low), .HIGH_DUTY_SLOPE(high),
    .SWITCH_DIVISOR(divisor));
  lbd_pwm_src u_pwm (.clk(clk), .duty(duty), .pwm(pwm));

  // Clock at 10 MHz.
  initial
  begin
    forever #50 clk = ~clk;
  end

  // One strobe cycle; the answer is looked at just after the edge that follows.
  task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= is_wr;
    rd <= !is_wr;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    `CHK(ack, 1'b1)
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    `CHK(rdata, e)
  endtask

  task automatic wait_chk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence: defaults, divisor table, stage gating, slopes, converter and dimming routes.
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h10, 8'h04);
    `CHK(divisor, 8'h10)
    rd_chk(8'h12, 8'h00);
    rd_chk(8'h55, 8'h00);
    for (int c = 0; c < 28; c++)
    begin
      access(1'b1, 8'h10, 8'(c));
      wait_chk(2);
      `CHK(divisor, c < 11 ? 8'h08 + 8'(2 * c) : (c < 27 ? DIV_TBL[c - 11] : 8'h10))
    end
    access(1'b1, 8'h10, 8'h00);
    access(1'b1, 8'h04, 8'h02);
    `CHK(en, 1'b1)
    @(posedge sw);
    t0 = $time;
    @(posedge sw);
    `CHK($time - t0, 64'h320)
    access(1'b1, 8'h04, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      wait_chk(1);
      `CHK(sw, 1'b0)
    end
    // With the clock enable low the block takes no write and gives no answer.
    @(posedge clk);
    ce <= 1'b0;
    wr <= 1'b1;
    addr <= 8'h04;
    wdata <= 8'h02;
    @(posedge clk);
    ce <= 1'b1;
    wr <= 1'b0;
    #1;
    `CHK(ack, 1'b0)
    `CHK(en, 1'b0)
    for (int s = 0; s < 16; s++)
    begin
      access(1'b1, 8'h12, 8'(s));
      `CHK(low, 2'(s))
      `CHK(high, 2'(s >> 2))
    end
    rd_chk(8'h12, 8'h0f);
    access(1'b1, 8'h12, 8'h00);
    access(1'b1, 8'h11, 8'hff);
    `CHK(src, 2'b10)
    `CHK(code, 7'h7f)
    `CHK(steps, 8'h80)
    access(1'b1, 8'h11, 8'h80);
    `CHK(steps, 8'h01)
    rd_chk(8'h11, 8'h80);
    access(1'b1, 8'h11, 8'h00);
    duty <= 14'h2000;
    wait_chk(2);
    `CHK(src, 2'b00)
    wait_chk(6);
    `CHK(src, 2'b01)
    duty <= 14'h0000;
    wait_chk(8);
    `CHK(src, 2'b00)
    print_verdict();
  end

  // Cuts a hang short well past the expected few hundred cycles.
  initial
  begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule
